/* File: dtc_defs.vh */
// constants for the dual timer/counter with external interrupt block
// Overview of operation
// - registers live at 80h-FFh, direct access only
// - addresses ending 0 or 8 are bit addressable
// - unimplemented bits and locations read as one
// - overflow flag set by hardware, cleared on vector
// - run bit switches each timer on or off
// - pin flag set on edge/level; edge cleared on vector, level follows pin
// - type bit picks falling edge or low level
// - gating bit requires pin high plus run bit
// - counter select counts pin falling edges
// - mode 00 is 8-bit with 5-bit prescaler
// - mode 01 is full 16-bit counter
// - mode 10 reloads low byte from high byte
// - timer 0 mode 11 splits into two bytes
// - timer 1 mode 11 stops and holds
// - count bytes at 8Ah, 8Bh, 8Ch, 8Dh
// - flags/run at 88h, mode register at 89h
// - timers keep running while cpu halted
// - deep sleep freezes all counts
// - fast clock select divides by 4, else 12
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// ==========================================
// register addresses
`define DTC_ADDR_FLAGS 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0_LOW 8'h8A
`define DTC_ADDR_T1_LOW 8'h8B
`define DTC_ADDR_T0_HIGH 8'h8C
`define DTC_ADDR_T1_HIGH 8'h8D
`define DTC_SPACE_BASE 8'h80

// ==========================================
// flags/run register fields
`define DTC_T1_FLAG 7
`define DTC_T1_RUN 6
`define DTC_T0_FLAG 5
`define DTC_T0_RUN 4
`define DTC_X1_PEND 3
`define DTC_X1_TYPE 2
`define DTC_X0_PEND 1
`define DTC_X0_TYPE 0

// ==========================================
// mode register fields, per nibble
`define DTC_GATE_BIT 3
`define DTC_CNT_BIT 2
`define DTC_MODE_13 2'h0
`define DTC_MODE_16 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// ==========================================
// reset values and clock dividers
`define DTC_RST_BYTE 8'h00
`define DTC_DIV_FAST 4'h3
`define DTC_DIV_SLOW 4'hB
`define DTC_UNMAPPED 8'hFF

`endif

/* File: dtc_pin_sync.v */
// synchroniser and falling-edge detector for one input pin
`timescale 1ns/1ps
module dtc_pin_sync (
    input wire sys_clk_i,
    input wire rst_i,
    input wire pin_i,
    output wire level_o,
    output wire fall_o
);
    reg meta_ff;
    reg sync_ff;
    reg prev_ff;

    // ==========================================
    // two-flop sync, then a third flop for edge history
    // high then low
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_o = sync_ff;
    assign fall_o = prev_ff & ~sync_ff;
endmodule

/* File: dtc_timer_top.v */
// dual timer/counter with external interrupt detection and register port
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_timer_top (
    input wire sys_clk_i,
    input wire rst_i,
    // direct-address register port
    input wire [7:0] reg_addr_i,
    input wire reg_direct_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_bit_wr_i,
    input wire [2:0] reg_bit_sel_i,
    input wire reg_bit_val_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // vector acknowledges from the interrupt controller
    input wire t0_vector_ack_i,
    input wire t1_vector_ack_i,
    input wire ext0_vector_ack_i,
    input wire ext1_vector_ack_i,
    // power state and clock selects
    input wire cpu_halt_request_i,
    input wire deep_sleep_request_i,
    input wire timer0_fast_clock_select_i,
    input wire timer1_fast_clock_select_i,
    // pins
    input wire t0_count_pin_i,
    input wire t1_count_pin_i,
    input wire ext0_external_interrupt_pin_i,
    input wire ext1_external_interrupt_pin_i,
    // flag outputs to the interrupt controller
    output reg timer0_overflow_flag_o,
    output reg timer1_overflow_flag_o,
    output reg ext0_pending_flag_o,
    output reg ext1_pending_flag_o
);
    reg [7:0] flags_ff;
    reg [7:0] mode_ff;
    reg [7:0] t0_low_ff;
    reg [7:0] t0_high_ff;
    reg [7:0] t1_low_ff;
    reg [7:0] t1_high_ff;
    reg [3:0] pre0_ff;
    reg [3:0] pre1_ff;
    reg [7:0] nxt_flags;
    reg [7:0] nxt_t0_low;
    reg [7:0] nxt_t0_high;
    reg [7:0] nxt_t1_low;
    reg [7:0] nxt_t1_high;
    reg [7:0] nxt_rdata;
    reg [7:0] cur_byte;
    reg [7:0] wr_byte;
    reg t0_ovf;
    reg t1_ovf;
    reg split_ovf;
    wire c0_lvl;
    wire c0_fall;
    wire c1_lvl;
    wire c1_fall;
    wire x0_lvl;
    wire x0_fall;
    wire x1_lvl;
    wire x1_fall;
    wire acc_ok;
    wire freeze;
    wire tick0;
    wire tick1;
    wire inc0;
    wire inc1;
    wire inc0_hi;
    wire en0;
    wire en1;
    wire [1:0] mode0;
    wire [1:0] mode1;

    // ==========================================
    // pin synchronisers
    dtc_pin_sync u_c0 (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(t0_count_pin_i),
        .level_o(c0_lvl), .fall_o(c0_fall));
    dtc_pin_sync u_c1 (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(t1_count_pin_i),
        .level_o(c1_lvl), .fall_o(c1_fall));
    dtc_pin_sync u_x0 (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(ext0_external_interrupt_pin_i),
        .level_o(x0_lvl), .fall_o(x0_fall));
    dtc_pin_sync u_x1 (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(ext1_external_interrupt_pin_i),
        .level_o(x1_lvl), .fall_o(x1_fall));

    // ==========================================
    // access qualification
    // direct only
    assign acc_ok = reg_direct_i & (reg_addr_i >= `DTC_SPACE_BASE);
    // deep sleep stops every count; halt is ignored on purpose
    assign freeze = deep_sleep_request_i;

    // ==========================================
    // internal prescalers, divide by 4 or 12 per timer
    // clock divide select
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pre0_ff <= 4'h0;
            pre1_ff <= 4'h0;
        end else if (!freeze) begin
            if (tick0)
                pre0_ff <= 4'h0;
            else
                pre0_ff <= pre0_ff + 4'h1;
            if (tick1)
                pre1_ff <= 4'h0;
            else
                pre1_ff <= pre1_ff + 4'h1;
        end
    end
    assign tick0 = pre0_ff >= (timer0_fast_clock_select_i ? `DTC_DIV_FAST : `DTC_DIV_SLOW);
    assign tick1 = pre1_ff >= (timer1_fast_clock_select_i ? `DTC_DIV_FAST : `DTC_DIV_SLOW);

    // ==========================================
    // count enables
    assign mode0 = mode_ff[1:0];
    assign mode1 = mode_ff[5:4];
    assign en0 = flags_ff[`DTC_T0_RUN] & (~mode_ff[`DTC_GATE_BIT] | x0_lvl);
    assign en1 = flags_ff[`DTC_T1_RUN] & (~mode_ff[4 + `DTC_GATE_BIT] | x1_lvl);
    assign inc0 = ~freeze & en0 & (mode_ff[`DTC_CNT_BIT] ? c0_fall : tick0);
    assign inc1 = ~freeze & en1 & (mode1 != `DTC_MODE_SPLIT) &
                  (mode_ff[4 + `DTC_CNT_BIT] ? c1_fall : tick1);
    // high byte of timer 0 runs on timer 1 run bit, internal clock
    assign inc0_hi = ~freeze & flags_ff[`DTC_T1_RUN] & tick0 & (mode0 == `DTC_MODE_SPLIT);

    // ==========================================
    // counter next state for both timers
    always @* begin
        nxt_t0_low = t0_low_ff;
        nxt_t0_high = t0_high_ff;
        nxt_t1_low = t1_low_ff;
        nxt_t1_high = t1_high_ff;
        t0_ovf = 1'b0;
        t1_ovf = 1'b0;
        split_ovf = 1'b0;
        if (inc0) begin
            case (mode0)
                `DTC_MODE_13: begin
                    nxt_t0_low = {3'h0, t0_low_ff[4:0] + 5'h01};
                    if (t0_low_ff[4:0] == 5'h1F) begin
                        nxt_t0_high = t0_high_ff + 8'h01;
                        t0_ovf = (t0_high_ff == 8'hFF);
                    end
                end
                `DTC_MODE_16: begin
                    {nxt_t0_high, nxt_t0_low} = {t0_high_ff, t0_low_ff} + 16'h0001;
                    t0_ovf = ({t0_high_ff, t0_low_ff} == 16'hFFFF);
                end
                `DTC_MODE_RELOAD: begin
                    t0_ovf = (t0_low_ff == 8'hFF);
                    nxt_t0_low = t0_ovf ? t0_high_ff : t0_low_ff + 8'h01;
                end
                default: begin
                    nxt_t0_low = t0_low_ff + 8'h01;
                    t0_ovf = (t0_low_ff == 8'hFF);
                end
            endcase
        end
        if (inc0_hi) begin
            nxt_t0_high = t0_high_ff + 8'h01;
            split_ovf = (t0_high_ff == 8'hFF);
        end
        if (inc1) begin
            case (mode1)
                `DTC_MODE_13: begin
                    nxt_t1_low = {3'h0, t1_low_ff[4:0] + 5'h01};
                    if (t1_low_ff[4:0] == 5'h1F) begin
                        nxt_t1_high = t1_high_ff + 8'h01;
                        t1_ovf = (t1_high_ff == 8'hFF);
                    end
                end
                `DTC_MODE_16: begin
                    {nxt_t1_high, nxt_t1_low} = {t1_high_ff, t1_low_ff} + 16'h0001;
                    t1_ovf = ({t1_high_ff, t1_low_ff} == 16'hFFFF);
                end
                `DTC_MODE_RELOAD: begin
                    t1_ovf = (t1_low_ff == 8'hFF);
                    nxt_t1_low = t1_ovf ? t1_high_ff : t1_low_ff + 8'h01;
                end
                default: begin
                    nxt_t1_low = t1_low_ff;
                end
            endcase
        end
    end

    // ==========================================
    // write data: whole byte, or one bit merged into the current value
    always @* begin
        case (reg_addr_i)
            `DTC_ADDR_FLAGS: cur_byte = flags_ff;
            `DTC_ADDR_MODE: cur_byte = mode_ff;
            `DTC_ADDR_T0_LOW: cur_byte = t0_low_ff;
            `DTC_ADDR_T1_LOW: cur_byte = t1_low_ff;
            `DTC_ADDR_T0_HIGH: cur_byte = t0_high_ff;
            `DTC_ADDR_T1_HIGH: cur_byte = t1_high_ff;
            default: cur_byte = `DTC_UNMAPPED;
        endcase
        wr_byte = reg_wdata_i;
        // bit access only at addresses ending 0 or 8
        if (reg_bit_wr_i) begin
            wr_byte = cur_byte;
            wr_byte[reg_bit_sel_i] = reg_bit_val_i;
        end
    end

    // ==========================================
    // flag register next state; hardware set beats any clear
    always @* begin
        nxt_flags = flags_ff;
        if (acc_ok && (reg_wr_i || (reg_bit_wr_i && reg_addr_i[2:0] == 3'h0)) &&
            reg_addr_i == `DTC_ADDR_FLAGS)
            nxt_flags = wr_byte;
        // clear on vector, set on overflow
        if (t0_vector_ack_i)
            nxt_flags[`DTC_T0_FLAG] = 1'b0;
        if (t1_vector_ack_i)
            nxt_flags[`DTC_T1_FLAG] = 1'b0;
        if (t0_ovf)
            nxt_flags[`DTC_T0_FLAG] = 1'b1;
        if (t1_ovf || split_ovf)
            nxt_flags[`DTC_T1_FLAG] = 1'b1;
        // edge mode cleared on vector, level mode follows pin
        // type bit selects edge or level
        if (flags_ff[`DTC_X0_TYPE]) begin
            if (ext0_vector_ack_i)
                nxt_flags[`DTC_X0_PEND] = 1'b0;
            if (x0_fall)
                nxt_flags[`DTC_X0_PEND] = 1'b1;
        end else begin
            nxt_flags[`DTC_X0_PEND] = ~x0_lvl;
        end
        if (flags_ff[`DTC_X1_TYPE]) begin
            if (ext1_vector_ack_i)
                nxt_flags[`DTC_X1_PEND] = 1'b0;
            if (x1_fall)
                nxt_flags[`DTC_X1_PEND] = 1'b1;
        end else begin
            nxt_flags[`DTC_X1_PEND] = ~x1_lvl;
        end
    end

    // ==========================================
    // register file; a write in the same cycle as a count wins the byte
    // count byte addresses; control addresses
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            flags_ff <= `DTC_RST_BYTE;
            mode_ff <= `DTC_RST_BYTE;
            t0_low_ff <= `DTC_RST_BYTE;
            t0_high_ff <= `DTC_RST_BYTE;
            t1_low_ff <= `DTC_RST_BYTE;
            t1_high_ff <= `DTC_RST_BYTE;
        end else begin
            flags_ff <= nxt_flags;
            t0_low_ff <= nxt_t0_low;
            t0_high_ff <= nxt_t0_high;
            t1_low_ff <= nxt_t1_low;
            t1_high_ff <= nxt_t1_high;
            if (acc_ok && reg_wr_i) begin
                case (reg_addr_i)
                    `DTC_ADDR_MODE: mode_ff <= wr_byte;
                    `DTC_ADDR_T0_LOW: t0_low_ff <= wr_byte;
                    `DTC_ADDR_T1_LOW: t1_low_ff <= wr_byte;
                    `DTC_ADDR_T0_HIGH: t0_high_ff <= wr_byte;
                    `DTC_ADDR_T1_HIGH: t1_high_ff <= wr_byte;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================
    // read path, registered; unmapped or indirect reads give all ones
    // unimplemented reads high
    always @* begin
        nxt_rdata = `DTC_UNMAPPED;
        if (acc_ok)
            nxt_rdata = cur_byte;
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= `DTC_UNMAPPED;
            timer0_overflow_flag_o <= 1'b0;
            timer1_overflow_flag_o <= 1'b0;
            ext0_pending_flag_o <= 1'b0;
            ext1_pending_flag_o <= 1'b0;
        end else begin
            if (reg_rd_i)
                reg_rdata_o <= nxt_rdata;
            timer0_overflow_flag_o <= nxt_flags[`DTC_T0_FLAG];
            timer1_overflow_flag_o <= nxt_flags[`DTC_T1_FLAG];
            ext0_pending_flag_o <= nxt_flags[`DTC_X0_PEND];
            ext1_pending_flag_o <= nxt_flags[`DTC_X1_PEND];
        end
    end
endmodule

/* File: dtc_pin_model.sv */
// far-side model of the count and external interrupt pins
`timescale 1ns/1ps
module dtc_pin_model (
    input wire sys_clk_i,
    input wire [3:0] pulse_i,
    input wire [3:0] hold_low_i,
    output wire [3:0] pin_o
);
// ==========================================
// pulse shaping
reg [3:0] low1_ff;
reg [3:0] low2_ff;
// each request gives a two-cycle low, so falls stay within the pin rate
always @(posedge sys_clk_i) begin
    low1_ff <= pulse_i;
    low2_ff <= low1_ff;
end
// pins idle high on their pull-ups
assign pin_o = ~(hold_low_i | low1_ff | low2_ff);
endmodule

/* File: dtc_timer_top_monitor.sv */
// checker for the register port and the timer0 and ext0 flag outputs of the timer block
`timescale 1ns/1ps
module dtc_timer_top_monitor (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_direct_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_bit_wr_i,
    input wire [2:0] reg_bit_sel_i,
    input wire reg_bit_val_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire t0_vector_ack_i,
    input wire ext0_vector_ack_i,
    input wire deep_sleep_request_i,
    input wire ext0_external_interrupt_pin_i,
    input wire timer0_overflow_flag_o,
    input wire ext0_pending_flag_o
);
// ==========================================
// shadow of the ext0 trigger type, which is not a port
reg type0_ff;
wire fl_sel = reg_direct_i && reg_addr_i == 8'h88;
wire quiet = !reg_wr_i && !reg_bit_wr_i;
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        type0_ff <= 1'b0;
    end else if (fl_sel && reg_wr_i) begin
        type0_ff <= reg_wdata_i[0];
    end else if (fl_sel && reg_bit_wr_i && reg_bit_sel_i == 3'h0) begin
        type0_ff <= reg_bit_val_i;
    end
end
default clocking @(posedge sys_clk_i); endclocking
default disable iff (rst_i);
// ==========================================
// sequences
sequence s_mode_wr;
    reg_wr_i && reg_direct_i && reg_addr_i == 8'h89;
endsequence
sequence s_mode_rd;
    reg_rd_i && reg_direct_i && reg_addr_i == 8'h89 && !reg_wr_i;
endsequence
// margin of six samples covers the two-flop sync lag
sequence s_level_steady;
    (!type0_ff && $stable(ext0_external_interrupt_pin_i) && quiet) [*6];
endsequence
sequence s_pin_high;
    ext0_external_interrupt_pin_i [*5];
endsequence
// ==========================================
// assertions
AST_INDIRECT_READ: assert property (reg_rd_i && !reg_direct_i |=> reg_rdata_o == 8'hFF)
    else $error("indirect read did not return all ones");
AST_UNMAPPED_READ: assert property (
    reg_rd_i && (reg_addr_i < 8'h88 || reg_addr_i > 8'h8D) |=> reg_rdata_o == 8'hFF)
    else $error("unmapped read did not return all ones");
AST_MODE_READBACK: assert property (s_mode_wr ##1 quiet ##1 s_mode_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("mode register read back wrong");
AST_RDATA_HOLDS: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
AST_ACK_CLEARS_T0: assert property (
    t0_vector_ack_i && deep_sleep_request_i && quiet |=> !timer0_overflow_flag_o)
    else $error("vector ack did not clear timer0 flag");
AST_SLEEP_HOLDS_T0: assert property (
    deep_sleep_request_i && quiet && !t0_vector_ack_i |=> $stable(timer0_overflow_flag_o))
    else $error("timer0 flag moved in deep sleep");
AST_LEVEL_FOLLOWS: assert property (
    s_level_steady |-> ext0_pending_flag_o == !ext0_external_interrupt_pin_i)
    else $error("level pending flag not following pin");
AST_EDGE_SETS: assert property (
    type0_ff && $fell(ext0_external_interrupt_pin_i) |-> ##[1:5] ext0_pending_flag_o)
    else $error("falling edge did not set pending flag");
AST_EDGE_ACK: assert property (
    s_pin_high ##0 (type0_ff && ext0_vector_ack_i && quiet) |=> !ext0_pending_flag_o)
    else $error("vector ack did not clear edge flag");
endmodule
bind dtc_timer_top dtc_timer_top_monitor i_mon (.sys_clk_i, .rst_i, .reg_addr_i, .reg_direct_i,
    .reg_wr_i, .reg_wdata_i, .reg_bit_wr_i, .reg_bit_sel_i, .reg_bit_val_i, .reg_rd_i, .reg_rdata_o,
    .t0_vector_ack_i, .ext0_vector_ack_i, .deep_sleep_request_i, .ext0_external_interrupt_pin_i,
    .timer0_overflow_flag_o, .ext0_pending_flag_o);

/* File: dtc_timer_top_tb.sv */
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module dtc_timer_top_tb;
reg sys_clk = 1'b0;
reg rst = 1'b1;
reg [7:0] addr = 8'h00;
reg [7:0] wd = 8'h00;
reg dir = 1'b1;
reg wr = 1'b0;
reg bwr = 1'b0;
reg [2:0] bsel = 3'h0;
reg bval = 1'b0;
reg rd = 1'b0;
reg halt = 1'b0;
reg sleep = 1'b0;
reg [1:0] fast = 2'h1;
reg [3:0] ack = 4'h0;
reg [3:0] pls = 4'h0;
reg [3:0] hold = 4'h0;
wire [3:0] pin;
wire [3:0] flg;
wire [7:0] rdata;
int mismatches = 0;
int num_checks = 0;
int n;
dtc_pin_model i_pins (.sys_clk_i(sys_clk), .pulse_i(pls), .hold_low_i(hold), .pin_o(pin));
dtc_timer_top i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(addr), .reg_direct_i(dir),
    .reg_wr_i(wr), .reg_wdata_i(wd), .reg_bit_wr_i(bwr), .reg_bit_sel_i(bsel), .reg_bit_val_i(bval),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .t0_vector_ack_i(ack[0]), .t1_vector_ack_i(ack[1]),
    .ext0_vector_ack_i(ack[2]), .ext1_vector_ack_i(ack[3]), .cpu_halt_request_i(halt),
    .deep_sleep_request_i(sleep), .timer0_fast_clock_select_i(fast[0]),
    .timer1_fast_clock_select_i(fast[1]), .t0_count_pin_i(pin[0]), .t1_count_pin_i(pin[1]),
    .ext0_external_interrupt_pin_i(pin[2]), .ext1_external_interrupt_pin_i(pin[3]),
    .timer0_overflow_flag_o(flg[0]), .timer1_overflow_flag_o(flg[1]),
    .ext0_pending_flag_o(flg[2]), .ext1_pending_flag_o(flg[3]));
// ==========================================
// clock, closing and watchdog
initial begin
    forever #50 sys_clk = ~sys_clk;
end
task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
// whole run needs well under a thousand cycles
initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    stop_test();
end
// ==========================================
// register and pin tasks, all entered and left at a falling edge
// an idle cycle after each strobe stops back-to-back calls toggling it in one step
task automatic wr_reg(input [7:0] a, input [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge sys_clk);
    wr = 1'b0;
    @(negedge sys_clk);
endtask
task automatic bit_wr(input [7:0] a, input [2:0] b, input v);
    addr = a;
    bsel = b;
    bval = v;
    bwr = 1'b1;
    @(negedge sys_clk);
    bwr = 1'b0;
    @(negedge sys_clk);
endtask
task automatic rd_chk(input [7:0] a, input [7:0] e);
    addr = a;
    rd = 1'b1;
    @(negedge sys_clk);
    rd = 1'b0;
    `CHK("read data", e, rdata)
    @(negedge sys_clk);
endtask
// waits for a flag to rise; with e low it checks that it stays clear
task automatic wait_flag(input int i, input int lim, input e);
    n = 0;
    while (flg[i] !== 1'b1 && n < lim) begin
        @(negedge sys_clk);
        n++;
    end
    `CHK("flag", e, flg[i])
endtask
task automatic pulse(input int i);
    pls[i] = 1'b1;
    @(negedge sys_clk);
    pls[i] = 1'b0;
    repeat (4) @(negedge sys_clk);
endtask
// the first interval after a divider change is discarded
task automatic tick(input int p);
    wait_flag(0, 40, 1'b1);
    for (int k = 0; k < 2; k++) begin
        ack[0] = 1'b1;
        @(negedge sys_clk);
        ack[0] = 1'b0;
        n = 1;
        while (flg[0] !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
    end
    `CHK("tick period", p, n)
endtask
task automatic setup(input [7:0] m, input [7:0] lo, input [7:0] hi);
    bit_wr(8'h88, 3'h4, 1'b0);
    wr_reg(8'h89, m);
    wr_reg(8'h8A, lo);
    wr_reg(8'h8C, hi);
    bit_wr(8'h88, 3'h5, 1'b0);
endtask
// ==========================================
// test sequence
initial begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    for (int a = 'h88; a <= 'h8D; a++) rd_chk(a[7:0], 8'h00);
    rd_chk(8'h8E, 8'hFF);
    rd_chk(8'h80, 8'hFF);
    dir = 1'b0;
    rd_chk(8'h88, 8'hFF);
    wr_reg(8'h89, 8'h5A);
    dir = 1'b1;
    rd_chk(8'h89, 8'h00);
    wr_reg(8'h89, 8'hA5);
    rd_chk(8'h89, 8'hA5);
    for (int a = 'h8A; a <= 'h8D; a++) wr_reg(a[7:0], a[7:0]);
    for (int a = 'h8A; a <= 'h8D; a++) rd_chk(a[7:0], a[7:0]);
    bit_wr(8'h88, 3'h2, 1'b1);
    bit_wr(8'h88, 3'h5, 1'b1);
    bit_wr(8'h89, 3'h0, 1'b0);
    rd_chk(8'h88, 8'h24);
    `CHK("soft set flag", 1'b1, flg[0])
    rd_chk(8'h89, 8'hA5);
    bit_wr(8'h88, 3'h2, 1'b0);
    $display("test registers finished");
    halt = 1'b1;
    setup(8'h02, 8'hFF, 8'hFF);
    bit_wr(8'h88, 3'h4, 1'b1);
    tick(4);
    fast = 2'h0;
    tick(12);
    sleep = 1'b1;
    ack[0] = 1'b1;
    @(negedge sys_clk);
    ack[0] = 1'b0;
    `CHK("flag after ack", 1'b0, flg[0])
    wait_flag(0, 30, 1'b0);
    sleep = 1'b0;
    wait_flag(0, 30, 1'b1);
    fast = 2'h1;
    $display("test divider and sleep finished");
    setup(8'h00, 8'h1F, 8'hFF);
    bit_wr(8'h88, 3'h4, 1'b1);
    wait_flag(0, 12, 1'b1);
    bit_wr(8'h88, 3'h4, 1'b0);
    rd_chk(8'h8C, 8'h00);
    setup(8'h01, 8'hFF, 8'hFE);
    bit_wr(8'h88, 3'h4, 1'b1);
    wait_flag(0, 8, 1'b0);
    bit_wr(8'h88, 3'h4, 1'b0);
    rd_chk(8'h8C, 8'hFF);
    $display("test wide modes finished");
    setup(8'h06, 8'hFD, 8'hFD);
    bit_wr(8'h88, 3'h4, 1'b1);
    pulse(0);
    pulse(0);
    `CHK("count flag", 1'b0, flg[0])
    pulse(0);
    wait_flag(0, 4, 1'b1);
    bit_wr(8'h88, 3'h4, 1'b0);
    rd_chk(8'h8A, 8'hFD);
    $display("test counter finished");
    hold = 4'hC;
    setup(8'h0A, 8'hFF, 8'hFF);
    bit_wr(8'h88, 3'h4, 1'b1);
    wait_flag(0, 30, 1'b0);
    `CHK("level flag", 1'b1, flg[2])
    `CHK("level flag 1", 1'b1, flg[3])
    hold = 4'h0;
    wait_flag(0, 20, 1'b1);
    $display("test gating finished");
    setup(8'h33, 8'hFF, 8'hFF);
    wr_reg(8'h8B, 8'hFF);
    bit_wr(8'h88, 3'h7, 1'b0);
    bit_wr(8'h88, 3'h6, 1'b1);
    wait_flag(1, 30, 1'b1);
    bit_wr(8'h88, 3'h6, 1'b0);
    rd_chk(8'h8B, 8'hFF);
    $display("test split mode finished");
    wr_reg(8'h89, 8'h60);
    wr_reg(8'h8B, 8'hFE);
    wr_reg(8'h8D, 8'h10);
    bit_wr(8'h88, 3'h7, 1'b0);
    bit_wr(8'h88, 3'h6, 1'b1);
    pulse(1);
    `CHK("t1 count flag", 1'b0, flg[1])
    pulse(1);
    wait_flag(1, 4, 1'b1);
    bit_wr(8'h88, 3'h6, 1'b0);
    rd_chk(8'h8B, 8'h10);
    $display("test timer 1 counter finished");
    bit_wr(8'h88, 3'h0, 1'b1);
    pulse(2);
    wait_flag(2, 8, 1'b1);
    repeat (6) @(negedge sys_clk);
    ack[2] = 1'b1;
    @(negedge sys_clk);
    ack[2] = 1'b0;
    `CHK("edge flag", 1'b0, flg[2])
    $display("test external edge finished");
    stop_test();
end
endmodule
